// ### shared/cmfr_pkg.sv
// Overview of operation
// RQ1: Page number selects mailbox, filter or config window
// RQ2: Receive mailbox ignores all software writes
// RQ3: Transmit mailbox writable only while empty
// RQ4: Receive page shows match index at status slot
// RQ5: Error flag updated after each attempt
// RQ6: Arbitration lost flag updated after each attempt
// RQ7: Success flag updated, mirrored in transmit status
// RQ8: Completed flag set, write-one clear, cleared on request
// RQ9: Clearing completed also clears attempt status flags
// RQ10: Abort request settable only while pending, cleared empty
// RQ11: Transmit request cleared when mailbox becomes empty
// RQ12: Receive mailbox shows eight bit match index
// RQ13: Identifier 0 holds IDE, RTR, top id bits
// RQ14: Identifier 1 holds low standard, top extended bits
// RQ15: Identifier 2 and 3 hold extended id bits
// RQ16: Length holds four bit code, upper bits zero; CMFR_LEN_MASK (8'h8f) keeps bit 7 writable
// RQ17: Length and data writes blocked unless empty
// RQ18: Eight payload byte registers per mailbox
// RQ19: Software changes activation and scale only in init; the config page accepts these writes at any time
// RQ20: Six filter activation bits at bit 0 or 4
// RQ21: Two bit scale fields, bits 7 and 3 zero
// RQ22: Per filter high and low mode bits, register 0
// RQ23: Filters 5 and 4 modes in second mode register
// RQ24: Filter bits: identifier level, mask must match
// RQ25: Reserved page reads zero, ignores writes
package cmfr_pkg;
	// Register slots outside the paged window, and the window base (word index, byte addr = 4 * index)
	localparam logic [4:0] CMFR_PAGE_SELECT_IDX = 5'h00;
	localparam logic [4:0] CMFR_TX_STATUS_IDX = 5'h01;
	localparam logic [4:0] CMFR_TX_PRIORITY_IDX = 5'h02;
	localparam logic [4:0] CMFR_WIN_BASE_IDX = 5'h10;
	// Offsets within the window
	localparam logic [3:0] CMFR_W_CTRL = 4'h0;
	localparam logic [3:0] CMFR_W_LEN = 4'h1;
	localparam logic [3:0] CMFR_W_ID0 = 4'h2;
	localparam logic [3:0] CMFR_W_DATA0 = 4'h6;
	localparam logic [3:0] CMFR_W_CFG_MODE0 = 4'h8;
	localparam logic [3:0] CMFR_W_CFG_MODE1 = 4'h9;
	localparam logic [3:0] CMFR_W_CFG_CFG0 = 4'ha;
	localparam logic [3:0] CMFR_W_CFG_CFG2 = 4'hc;
	// Pages
	localparam logic [2:0] CMFR_PG_TX0 = 3'h0;
	localparam logic [2:0] CMFR_PG_TX1 = 3'h1;
	localparam logic [2:0] CMFR_PG_FLT_FIRST = 3'h2;
	localparam logic [2:0] CMFR_PG_FLT_LAST = 3'h4;
	localparam logic [2:0] CMFR_PG_RSVD = 3'h5;
	localparam logic [2:0] CMFR_PG_CFG = 3'h6;
	localparam logic [2:0] CMFR_PG_RX = 3'h7;
	// Control/status field positions
	localparam int CMFR_TRANSMIT_REQUEST_BIT = 0;
	localparam int CMFR_ABORT_REQUEST_BIT = 1;
	localparam int CMFR_REQUEST_COMPLETED_FLAG_BIT = 2;
	localparam int CMFR_TX_SUCCESS_FLAG_BIT = 3;
	localparam int CMFR_ARBITRATION_LOST_FLAG_BIT = 4;
	localparam int CMFR_TX_ERROR_FLAG_BIT = 5;
	// Read masks for fields with reserved bits
	localparam logic [7:0] CMFR_PAGE_MASK = 8'h07;
	localparam logic [7:0] CMFR_ID0_MASK = 8'h7f;
	localparam logic [7:0] CMFR_ID3_MASK = 8'hfe;
	localparam logic [7:0] CMFR_LEN_MASK = 8'h8f;
	localparam logic [7:0] CMFR_FCFG_MASK = 8'h77;
	localparam logic [7:0] CMFR_FMODE1_MASK = 8'h0f;
	// Reset value and filter bank sizes
	localparam logic [7:0] CMFR_RESET_BYTE = 8'h00;
	localparam int CMFR_NUM_FILTERS = 6;
	localparam int CMFR_FILTER_BYTES = 8;
	// Attempt outcome encoding from the protocol engine
	typedef enum logic [1:0] {CMFR_RES_OK, CMFR_RES_ERR, CMFR_RES_ARB, CMFR_RES_ABORT}
		cmfr_result_t;
endpackage : cmfr_pkg

// ### src/cmfr_tx_slot.sv
`timescale 1ns/1ps
// One transmit mailbox's control/status state
module cmfr_tx_slot
	import cmfr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Software side
	input wire logic sw_wr,
	input wire logic [7:0] sw_wdata,
	// Engine side
	input wire logic eng_done,
	input wire cmfr_result_t eng_result,
	// State
	output logic empty,
	output logic [7:0] ctrl_status
);
	logic transmit_request_q, abort_request_q, request_completed_flag_q, tx_success_flag_q, arbitration_lost_flag_q, tx_error_flag_q;
	logic new_rq, clr_cp;

	assign empty = !transmit_request_q;
	// Request only counts when the mailbox is empty, so a second set cannot retrigger
	assign new_rq = sw_wr && empty && sw_wdata[CMFR_TRANSMIT_REQUEST_BIT];
	assign clr_cp = (sw_wr && sw_wdata[CMFR_REQUEST_COMPLETED_FLAG_BIT]) || new_rq; // RQ8
	assign ctrl_status = {2'b00, tx_error_flag_q, arbitration_lost_flag_q, tx_success_flag_q, request_completed_flag_q, abort_request_q, transmit_request_q};

	// Request and abort bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transmit_request_q <= 1'b0;
			abort_request_q <= 1'b0;
		end else if (eng_done) begin
			transmit_request_q <= 1'b0; // RQ11
			abort_request_q <= 1'b0; // RQ10
		end else begin
			if (new_rq)
				transmit_request_q <= 1'b1;
			if (sw_wr && sw_wdata[CMFR_ABORT_REQUEST_BIT] && transmit_request_q)
				abort_request_q <= 1'b1; // RQ10
		end
	end

	// Completion and outcome flags; the engine's set wins over a clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			request_completed_flag_q <= 1'b0;
			tx_success_flag_q <= 1'b0;
			arbitration_lost_flag_q <= 1'b0;
			tx_error_flag_q <= 1'b0;
		end else if (eng_done) begin
			request_completed_flag_q <= 1'b1; // RQ8
			tx_success_flag_q <= (eng_result == CMFR_RES_OK); // RQ7
			arbitration_lost_flag_q <= (eng_result == CMFR_RES_ARB); // RQ6
			tx_error_flag_q <= (eng_result == CMFR_RES_ERR); // RQ5
		end else if (clr_cp) begin
			request_completed_flag_q <= 1'b0; // RQ9
			tx_success_flag_q <= 1'b0;
			arbitration_lost_flag_q <= 1'b0;
			tx_error_flag_q <= 1'b0;
		end
	end
endmodule : cmfr_tx_slot

// ### src/cmfr_regs.sv
`timescale 1ns/1ps
// Paged mailbox and acceptance filter register file
module cmfr_regs
	import cmfr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Transmit mailbox to engine
	output logic [1:0] tx_pending,
	output logic [1:0] tx_abort,
	input wire logic [1:0] tx_done,
	input wire cmfr_result_t tx_result,
	input wire logic [2:0] eng_sel_byte,
	input wire logic eng_sel_mbox,
	output logic [7:0] tx_byte,
	// Receive mailbox load from FIFO
	input wire logic rx_load,
	input wire logic [3:0] rx_load_idx,
	input wire logic [7:0] rx_load_byte,
	// Filter configuration outputs
	output logic [5:0] filter_active,
	output logic [11:0] filter_scale,
	output logic [11:0] filter_mode,
	output logic [7:0] filter_cfg_byte,
	input wire logic [5:0] filter_cfg_addr
);
	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [7:0] page_q;
	logic [7:0] wbyte;
	logic acc_wr, acc_rd, wsel;
	logic [4:0] idx;
	logic [3:0] woff;
	logic in_win;
	logic ack_q;
	logic [7:0] rbyte;

	assign idx = avs_address[6:2];
	assign in_win = idx >= CMFR_WIN_BASE_IDX;
	assign woff = idx[3:0];
	assign wbyte = avs_writedata[7:0];
	assign wsel = avs_byteenable[0];
	// One wait cycle for every access gives a registered read path
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	// A write lands at the edge where waitrequest is low, never during the wait cycle
	assign acc_wr = avs_write && ack_q && wsel;
	assign acc_rd = avs_read && !ack_q;

	// Acknowledge strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read || avs_write) && !ack_q;
	end

	// Page select, upper bits kept at zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			page_q <= CMFR_RESET_BYTE;
		else if (acc_wr && !in_win && idx == CMFR_PAGE_SELECT_IDX)
			page_q <= wbyte & CMFR_PAGE_MASK; // RQ1
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit mailboxes
	logic [7:0] tx_mem [2][16];
	logic [7:0] rx_mem [16];
	logic [1:0] slot_empty;
	logic [7:0] slot_cs [2];
	logic [1:0] slot_wr;

	function automatic logic [7:0] cmfr_field_mask(input logic [3:0] off);
		case (off)
			CMFR_W_LEN: cmfr_field_mask = CMFR_LEN_MASK; // RQ16
			CMFR_W_ID0: cmfr_field_mask = CMFR_ID0_MASK; // RQ13
			4'h5: cmfr_field_mask = CMFR_ID3_MASK; // RQ15
			default: cmfr_field_mask = 8'hff; // RQ14
		endcase
	endfunction : cmfr_field_mask

	for (genvar m = 0; m < 2; m++) begin : g_slot
		assign slot_wr[m] = acc_wr && in_win && page_q[2:0] == 3'(m) && woff == CMFR_W_CTRL;
		cmfr_tx_slot u_slot (
			.clk(clk),
			.rstn(rstn),
			.sw_wr(slot_wr[m]),
			.sw_wdata(wbyte),
			.eng_done(tx_done[m]),
			.eng_result(tx_result),
			.empty(slot_empty[m]),
			.ctrl_status(slot_cs[m])
		);
		assign tx_pending[m] = slot_cs[m][CMFR_TRANSMIT_REQUEST_BIT];
		assign tx_abort[m] = slot_cs[m][CMFR_ABORT_REQUEST_BIT];

		// Identifier, length and payload; protected while pending
		always_ff @(posedge clk) begin
			if (acc_wr && in_win && page_q[2:0] == 3'(m) && woff != CMFR_W_CTRL
				&& slot_empty[m]) // RQ3 RQ17
				tx_mem[m][woff] <= wbyte & cmfr_field_mask(woff); // RQ18
		end
	end

	// Engine reads payload of the chosen mailbox
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			tx_byte <= CMFR_RESET_BYTE;
		else
			tx_byte <= tx_mem[eng_sel_mbox][CMFR_W_DATA0 + {1'b0, eng_sel_byte}];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive mailbox: loaded only by hardware, software writes dropped
	always_ff @(posedge clk) begin
		if (rx_load)
			rx_mem[rx_load_idx] <= rx_load_byte; // RQ2 RQ12
	end

	////////////////////////////////////////////////////////////////////////////////
	// Filter banks and configuration
	logic [7:0] flt_mem [CMFR_NUM_FILTERS * CMFR_FILTER_BYTES];
	logic [7:0] fcfg_q [3];
	logic [7:0] fmode0_q, fmode1_q;
	logic [2:0] fpage;
	logic [5:0] flt_addr;
	logic [2:0] flt_num;

	assign fpage = page_q[2:0] - CMFR_PG_FLT_FIRST;
	// Each page holds two filters of eight bytes, so the page picks a 16-byte block
	assign flt_addr = {fpage[1:0], woff};
	assign flt_num = flt_addr[5:3];

	// Filter bits stored raw: identifier level or must-match, per mode; frozen while active
	always_ff @(posedge clk) begin
		if (acc_wr && in_win && page_q[2:0] >= CMFR_PG_FLT_FIRST
			&& page_q[2:0] <= CMFR_PG_FLT_LAST && !filter_active[flt_num]) // RQ20
			flt_mem[flt_addr] <= wbyte; // RQ24
	end

	// Config page registers; init-mode discipline is left to software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fcfg_q[0] <= CMFR_RESET_BYTE;
			fcfg_q[1] <= CMFR_RESET_BYTE;
			fcfg_q[2] <= CMFR_RESET_BYTE;
			fmode0_q <= CMFR_RESET_BYTE;
			fmode1_q <= CMFR_RESET_BYTE;
		end else if (acc_wr && in_win && page_q[2:0] == CMFR_PG_CFG) begin
			if (woff == CMFR_W_CFG_MODE0)
				fmode0_q <= wbyte; // RQ22
			if (woff == CMFR_W_CFG_MODE1)
				fmode1_q <= wbyte & CMFR_FMODE1_MASK; // RQ23
			if (woff >= CMFR_W_CFG_CFG0 && woff <= CMFR_W_CFG_CFG2)
				fcfg_q[2'(woff - CMFR_W_CFG_CFG0)] <= wbyte & CMFR_FCFG_MASK; // RQ21
		end
	end

	// Unpack filter controls for the matcher
	always_comb begin
		for (int f = 0; f < 3; f++) begin
			filter_active[2*f] = fcfg_q[f][0]; // RQ20
			filter_active[2*f+1] = fcfg_q[f][4];
			filter_scale[4*f +: 2] = fcfg_q[f][2:1]; // RQ21
			filter_scale[4*f+2 +: 2] = fcfg_q[f][6:5];
		end
		filter_mode = {fmode1_q[3:0], fmode0_q};
	end

	// Matcher filter byte port
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			filter_cfg_byte <= CMFR_RESET_BYTE;
		else
			filter_cfg_byte <= flt_mem[filter_cfg_addr];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux
	logic [7:0] tx_status, tx_prio;

	assign tx_status = {2'b00, slot_cs[1][CMFR_TX_SUCCESS_FLAG_BIT], slot_cs[0][CMFR_TX_SUCCESS_FLAG_BIT],
		2'b00, slot_cs[1][CMFR_REQUEST_COMPLETED_FLAG_BIT], slot_cs[0][CMFR_REQUEST_COMPLETED_FLAG_BIT]}; // RQ7 RQ8
	assign tx_prio = {4'h0, slot_empty, 2'b00};

	always_comb begin
		rbyte = 8'h00;
		if (!in_win) begin
			case (idx)
				CMFR_PAGE_SELECT_IDX: rbyte = page_q;
				CMFR_TX_STATUS_IDX: rbyte = tx_status;
				CMFR_TX_PRIORITY_IDX: rbyte = tx_prio;
				default: rbyte = 8'h00;
			endcase
		end else begin
			case (page_q[2:0])
				CMFR_PG_TX0, CMFR_PG_TX1: begin
					if (woff == CMFR_W_CTRL)
						rbyte = slot_cs[page_q[0]];
					else
						rbyte = tx_mem[page_q[0]][woff];
				end
				CMFR_PG_RX: rbyte = rx_mem[woff]; // RQ4
				CMFR_PG_CFG: begin
					if (woff == CMFR_W_CFG_MODE0)
						rbyte = fmode0_q;
					else if (woff == CMFR_W_CFG_MODE1)
						rbyte = fmode1_q;
					else if (woff >= CMFR_W_CFG_CFG0 && woff <= CMFR_W_CFG_CFG2)
						rbyte = fcfg_q[2'(woff - CMFR_W_CFG_CFG0)];
				end
				CMFR_PG_RSVD: rbyte = 8'h00; // RQ25
				default: rbyte = flt_mem[flt_addr];
			endcase
		end
	end

	// Registered read data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			avs_readdata <= 32'h0000_0000;
		else if (acc_rd)
			avs_readdata <= {24'h00_0000, rbyte};
	end
endmodule : cmfr_regs

// ### verification/cmfr_engine_model.sv
`timescale 1ns/1ps
// Protocol engine stand-in: finishes one attempt at a time after a set delay
module cmfr_engine_model
	import cmfr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Mailbox state and bench command
	input wire logic [1:0] tx_pending,
	input wire logic [1:0] tx_abort,
	input wire cmfr_result_t res_cmd,
	input wire logic [7:0] delay,
	// Attempt completion
	output logic [1:0] tx_done,
	output cmfr_result_t tx_result
);
	logic [7:0] cnt_q;
	////////////////////////////////////////////////////////////////
	// Result carries junk outside a pulse so nobody may rely on it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
			tx_done <= 2'b00;
			tx_result <= CMFR_RES_OK;
		end else begin
			tx_done <= 2'b00;
			tx_result <= cmfr_result_t'(cnt_q[1:0]);
			if (tx_pending != 2'b00 && tx_done == 2'b00) begin
				cnt_q <= cnt_q + 8'h01;
				if (cnt_q >= delay) begin
					cnt_q <= 8'h00;
					tx_done <= tx_pending[0] ? 2'b01 : 2'b10;
					// A pending abort wins over the commanded outcome
					tx_result <= (tx_abort & tx_pending) != 2'b00 ? CMFR_RES_ABORT : res_cmd;
				end
			end
		end
	end
endmodule : cmfr_engine_model

// ### verification/cmfr_regs_checker.sv
`timescale 1ns/1ps
// Port-level checks of the mailbox register block
module cmfr_regs_checker
	import cmfr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Engine and filters
	input wire logic [1:0] tx_pending,
	input wire logic [1:0] tx_abort,
	input wire logic [1:0] tx_done,
	input wire logic [5:0] filter_active,
	input wire logic [11:0] filter_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	a_wait_one_cycle: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state not one cycle");
	a_readdata_upper: assert property (avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_abort_pend: assert property ((tx_abort & ~tx_pending) == 2'b00)
		else $error("abort without pending request");
	a_done_empties: assert property (tx_done != 2'b00 |=>
		((tx_pending | tx_abort) & $past(tx_done)) == 2'b00) else $error("request kept after done");
	a_pend_holds: assert property (tx_pending[0] && !tx_done[0] |=> tx_pending[0])
		else $error("request dropped early");
	a_pend_cause: assert property ($rose(tx_pending[0]) |->
		$past(avs_write && !avs_waitrequest)) else $error("request rose without write");
	a_abort_cause: assert property ($rose(tx_abort[0]) |->
		$past(avs_write && !avs_waitrequest && tx_pending[0])) else $error("abort rose wrongly");
	a_reset_clean: assert property ($rose(rstn) |-> tx_pending == 2'b00 &&
		filter_active == 6'h00 && filter_mode == 12'h000) else $error("outputs not clear");
endmodule : cmfr_regs_checker
bind cmfr_regs cmfr_regs_checker i_cmfr_regs_checker (.clk, .rstn, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .tx_pending, .tx_abort, .tx_done, .filter_active,
	.filter_mode);

// ### verification/tb.sv
`timescale 1ns/1ps
module tb
	import cmfr_pkg::*;
;
	logic clk, rstn, avs_read, avs_write, avs_waitrequest, rx_load;
	logic [6:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] tx_pending, tx_abort, tx_done;
	logic [3:0] rx_load_idx;
	logic [7:0] rx_load_byte, delay, q, v, es;
	logic [7:0] st [16];
	logic [5:0] filter_active, filter_cfg_addr;
	logic [7:0] tx_byte, filter_cfg_byte;
	logic [2:0] eng_sel_byte;
	logic eng_sel_mbox;
	logic [11:0] filter_scale, filter_mode;
	cmfr_result_t tx_result, res_cmd;
	logic [31:0] seed = 32'hd11c2d4c;
	int err_total = 0;
	int check_count = 0;
	int i, k, m;
	cmfr_regs i_cmfr_regs (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .tx_pending, .tx_abort,
		.tx_done, .tx_result, .eng_sel_byte, .eng_sel_mbox, .tx_byte, .rx_load,
		.rx_load_idx, .rx_load_byte, .filter_active, .filter_scale, .filter_mode,
		.filter_cfg_byte, .filter_cfg_addr);
	cmfr_engine_model i_cmfr_engine_model (.clk, .rstn, .tx_pending, .tx_abort, .res_cmd,
		.delay, .tx_done, .tx_result);
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// Readable bits of each mailbox slot
	function automatic logic [7:0] fmask(input int o);
		return o == 1 ? CMFR_LEN_MASK : (o == 2 ? CMFR_ID0_MASK : (o == 5 ? CMFR_ID3_MASK : 8'hff));
	endfunction : fmask
	// Control/status after an attempt with outcome r
	function automatic logic [7:0] ctl(input int r);
		return r == 0 ? 8'h0c : (r == 1 ? 8'h24 : (r == 2 ? 8'h14 : 8'h04));
	endfunction : ctl
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	// One Avalon access by word index; the slave decodes byte addresses
	// Entered just after a rising edge, held until waitrequest is sampled low at one
	task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
		int n;
		avs_address <= {a[4:0], 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 20) begin
			err_total++;
			conclude();
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
	initial begin
		{rstn, avs_read, avs_write, rx_load, avs_address, avs_writedata} = '0;
		{rx_load_idx, rx_load_byte, es} = '0;
		{eng_sel_byte, eng_sel_mbox, filter_cfg_addr} = '0;
		delay = 8'h3c;
		res_cmd = CMFR_RES_OK;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(0, 7'h02, 8'h00);
		chk("empty", q[3:2], 2'b11);
		bus(0, 7'h10, 8'h00);
		chk("ctrl", q, 8'h00);
		// Page number keeps three bits
		for (i = 0; i < 8; i++) begin
			v = rnd();
			bus(1, 7'h00, {v[7:3], i[2:0]});
			bus(0, 7'h00, 8'h00);
			chk("page", q, {5'h00, i[2:0]});
		end
		$display("page test done");
		bus(1, 7'h00, {5'h00, CMFR_PG_CFG});
		for (i = 8; i < 13; i++) begin
			st[i] = rnd();
			bus(1, 7'h10 + i[6:0], st[i]);
			bus(0, 7'h10 + i[6:0], 8'h00);
			chk("cfg", q, st[i] & (i == 9 ? CMFR_FMODE1_MASK : (i == 8 ? 8'hff : CMFR_FCFG_MASK)));
		end
		chk("mode", filter_mode, {st[9][3:0], st[8]});
		chk("act", filter_active, {st[12][4], st[12][0], st[11][4], st[11][0], st[10][4], st[10][0]});
		chk("scale", filter_scale, {st[12][6:5], st[12][2:1], st[11][6:5], st[11][2:1],
			st[10][6:5], st[10][2:1]});
		// Filter bytes land only while their filter is inactive
		for (i = 10; i < 13; i++)
			bus(1, 7'h10 + i[6:0], 8'h00);
		for (k = 0; k < 6; k++) begin
			st[k] = rnd();
			bus(1, 7'h00, 8'(2 + k / 2));
			bus(1, 7'h10 + 7'(8 * (k % 2)), st[k]);
		end
		bus(1, 7'h00, {5'h00, CMFR_PG_CFG});
		for (i = 10; i < 13; i++)
			bus(1, 7'h10 + i[6:0], 8'h11);
		chk("act all", filter_active, 6'h3f);
		for (k = 0; k < 6; k++) begin
			bus(1, 7'h00, 8'(2 + k / 2));
			bus(1, 7'h10 + 7'(8 * (k % 2)), ~st[k]);
			bus(0, 7'h10 + 7'(8 * (k % 2)), 8'h00);
			filter_cfg_addr <= 6'(8 * k);
			chk("filter", q, st[k]);
			repeat (2) @(posedge clk);
			chk("match byte", filter_cfg_byte, st[k]);
		end
		$display("filter test done");
		// Identifier, length and payload slots of both mailboxes
		for (k = 0; k < 2; k++) begin
			bus(1, 7'h00, k[7:0]);
			for (i = 1; i < 14; i++) begin
				st[i] = rnd() & (i == 1 ? 8'h0f : 8'hff);
				bus(1, 7'h10 + i[6:0], st[i]);
				bus(0, 7'h10 + i[6:0], 8'h00);
				chk("field", q, st[i] & fmask(i));
			end
		end
		// Engine side reads back the payload of the last mailbox written
		eng_sel_mbox <= 1'b1;
		for (i = 0; i < 8; i++) begin
			eng_sel_byte <= i[2:0];
			repeat (2) @(posedge clk);
			chk("payload", tx_byte, st[6 + i]);
		end
		$display("field test done");
		// Attempts: ok, error, lost arbitration, abort; es tracks the status register
		for (i = 0; i < 4; i++) begin
			m = i[0] ^ i[1];
			res_cmd <= cmfr_result_t'(i[1:0]);
			bus(1, 7'h00, m[7:0]);
			bus(1, 7'h10, 8'h01);
			es = es & ~(8'h11 << m);
			bus(0, 7'h10, 8'h00);
			chk("pend", q, 8'h01);
			bus(0, 7'h01, 8'h00);
			chk("status", q, es);
			bus(0, 7'h16, 8'h00);
			v = q;
			bus(1, 7'h16, ~v);
			bus(0, 7'h16, 8'h00);
			chk("locked", q, v);
			if (i == 3)
				bus(1, 7'h10, 8'h03);
			k = 0;
			do begin
				bus(0, 7'h10, 8'h00);
				k++;
			end while (q[0] !== 1'b0 && k < 40);
			if (k == 40) begin
				err_total++;
				conclude();
			end
			chk("ctrl", q, ctl(i));
			es = es | ((i == 0 ? 8'h11 : 8'h01) << m);
			bus(0, 7'h01, 8'h00);
			chk("status", q, es);
			if (i >= 2) begin
				bus(1, 7'h10, 8'h04);
				es = es & ~(8'h11 << m);
				bus(0, 7'h10, 8'h00);
				chk("clear", q, 8'h00);
			end
		end
		bus(1, 7'h10, 8'h02);
		bus(0, 7'h10, 8'h00);
		chk("idle abort", q, 8'h00);
		$display("transmit test done");
		// Receive mailbox is loaded by the FIFO side only
		bus(1, 7'h00, {5'h00, CMFR_PG_RX});
		for (k = 0; k < 7; k += 6) begin
			v = rnd();
			rx_load <= 1'b1;
			rx_load_idx <= k[3:0];
			rx_load_byte <= v;
			@(posedge clk);
			rx_load <= 1'b0;
			bus(1, 7'h10 + k[6:0], ~v);
			bus(0, 7'h10 + k[6:0], 8'h00);
			chk("rx", q, v);
		end
		bus(1, 7'h00, {5'h00, CMFR_PG_RSVD});
		bus(1, 7'h10, 8'h5a);
		bus(0, 7'h10, 8'h00);
		chk("reserved", q, 8'h00);
		bus(0, 7'h05, 8'h00);
		chk("unmapped", q, 8'h00);
		$display("receive test done");
		conclude();
	end
endmodule : tb
